// ===== hdl/pevic_pkg.sv
package pevic_pkg;

   // Register indices and byte addresses. The indices are not all multiples of four, so each
   // register takes one aligned word and its byte address is four times its index.
   localparam logic [7:0]  CTRL_IDX        = 8'h11;
   localparam logic [7:0]  STAT_IDX        = 8'h12;
   localparam logic [11:0] CTRL_ADDR       = 12'h044;
   localparam logic [11:0] STAT_ADDR       = 12'h048;
   localparam logic [11:0] EVT_ADDR        = 12'h080;

   // Control register fields.
   localparam int          CTRL_COL_FD     = 4;
   localparam int          CTRL_POL        = 3;
   localparam int          CTRL_TEST       = 2;
   localparam int          CTRL_GEN        = 1;
   localparam int          CTRL_OE         = 0;
   localparam logic [4:0]  CTRL_RST        = 5'h08;
   localparam logic [4:0]  CTRL_WMASK      = 5'h1f;

   // Status register fields: flags at 13:8, enables at 5:0.
   localparam int          STAT_FLAG_LSB   = 8;
   localparam int          NUM_EVT         = 6;
   localparam logic [5:0]  EN_RST          = 6'h00;

   // Event order, bit 5 down to bit 0.
   localparam int          EV_LINK         = 5;
   localparam int          EV_SPEED        = 4;
   localparam int          EV_DUPLEX       = 3;
   localparam int          EV_ANEG         = 2;
   localparam int          EV_FC_HF        = 1;
   localparam int          EV_RE_HF        = 0;

   // Half-full thresholds of the two counters.
   localparam logic [7:0]  FC_HALF         = 8'h7f;
   localparam logic [15:0] RE_HALF         = 16'h7fff;

endpackage : pevic_pkg

// ===== hdl/pevic_evt_if.sv
`timescale 1ns/10ps
interface pevic_evt_if;
   logic [5:0] pulse;
   logic [5:0] flags;
   logic       clear;
   modport src (output pulse, output clear, input flags);
   modport dst (input pulse, input clear, output flags);
endinterface : pevic_evt_if

// ===== hdl/pevic_flags.sv
`timescale 1ns/10ps
module pevic_flags (
   input  wire logic pclk,
   input  wire logic presetn,
   pevic_evt_if.dst  evt
);

   logic [5:0] flag_q;
   logic [5:0] flag_d;

   // A new event wins over a read clear in the same cycle, so it is never lost.
   assign flag_d    = (evt.clear ? 6'h00 : flag_q) | evt.pulse;
   assign evt.flags = flag_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 6'h00;
      end else begin
         flag_q <= flag_d;
      end
   end

endmodule : pevic_flags

// ===== hdl/pevic_top.sv
`timescale 1ns/10ps
module pevic_top #(
   parameter int FC_WIDTH = 8,
   parameter int RE_WIDTH = 16
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                link_up,
   input  wire logic                speed_100,
   input  wire logic                full_duplex,
   input  wire logic                aneg_done,
   input  wire logic [FC_WIDTH-1:0] false_carrier_counter,
   input  wire logic [RE_WIDTH-1:0] receive_error_counter,
   input  wire logic                collision_raw,
   output logic                     collision_out,
   input  wire logic                irq_or_powerdown_pin_i,
   output logic                     irq_or_powerdown_pin_o,
   output logic                     irq_or_powerdown_pin_oe,
   output logic                     powerdown_req
);

   ////////////////////////////////////////////////////////////////////////////////////////////////

   logic [4:0]  ctrl_q;
   logic [5:0]  en_q;
   logic        link_q;
   logic        speed_q;
   logic        duplex_q;
   logic        aneg_q;
   logic        fc_over_q;
   logic        re_over_q;
   logic        started_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        pin_o_q;
   logic        pin_oe_q;
   logic        pwdn_q;
   logic        col_q;

   pevic_evt_if evt ();

   pevic_flags u_flags (
      .pclk    (pclk),
      .presetn (presetn),
      .evt     (evt)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Bus decode. The slave answers in the first access cycle, so there are no wait states.

   wire        setup    = psel && !penable;
   wire        access   = psel && penable;
   wire        hit_ctrl = (paddr == pevic_pkg::CTRL_ADDR);
   wire        hit_stat = (paddr == pevic_pkg::STAT_ADDR);
   wire        mapped   = hit_ctrl || hit_stat;
   wire        wr_ok    = access && pwrite && mapped && pready_q;
   wire        wr_ctrl  = wr_ok && hit_ctrl && pstrb[0];
   wire        wr_stat  = wr_ok && hit_stat && pstrb[0];
   wire        rd_stat  = setup && !pwrite && hit_stat;

   // Low byte of the write data only; reserved bits are dropped here.
   wire [4:0]  ctrl_d   = pwdata[4:0] & pevic_pkg::CTRL_WMASK;
   wire [5:0]  en_d     = pwdata[5:0];

   wire [31:0] ctrl_rd  = {27'h0000000, ctrl_q};
   wire [31:0] stat_rd  = {16'h0000, 2'h0, evt.flags, 2'h0, en_q};
   wire [31:0] rd_mux   = hit_ctrl ? ctrl_rd : (hit_stat ? stat_rd : 32'h00000000);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Event detection. In the first cycle after reset the link, speed, duplex and autoneg events only capture their levels, to avoid a false change.

   wire        fc_over  = false_carrier_counter > FC_WIDTH'(pevic_pkg::FC_HALF);
   wire        re_over  = receive_error_counter > RE_WIDTH'(pevic_pkg::RE_HALF);

   assign evt.pulse[pevic_pkg::EV_LINK]   = started_q && (link_up != link_q);
   assign evt.pulse[pevic_pkg::EV_SPEED]  = started_q && (speed_100 != speed_q);
   assign evt.pulse[pevic_pkg::EV_DUPLEX] = started_q && (full_duplex != duplex_q);
   assign evt.pulse[pevic_pkg::EV_ANEG]   = started_q && aneg_done && !aneg_q;
   assign evt.pulse[pevic_pkg::EV_FC_HF]  = fc_over && !fc_over_q;
   assign evt.pulse[pevic_pkg::EV_RE_HF]  = re_over && !re_over_q;

   // Reading the status clears the flags; the read data is sampled in the setup cycle.
   assign evt.clear = rd_stat;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Pin behaviour.

   wire        ev_irq   = ctrl_q[pevic_pkg::CTRL_GEN] && |(evt.flags & en_q);
   wire        irq_cond = ctrl_q[pevic_pkg::CTRL_TEST] || ev_irq;
   wire        pin_oe_d = ctrl_q[pevic_pkg::CTRL_OE];
   // Polarity one means idle high and active low.
   wire        pin_o_d  = ctrl_q[pevic_pkg::CTRL_POL] ? !irq_cond : irq_cond;
   // In power-down mode the pin is an input; its active level is taken as low.
   wire        pwdn_d   = !pin_oe_d && !irq_or_powerdown_pin_i;
   wire        col_d    = collision_raw && (!full_duplex || ctrl_q[pevic_pkg::CTRL_COL_FD]);

   ////////////////////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= pevic_pkg::CTRL_RST;
         en_q   <= pevic_pkg::EN_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= ctrl_d;
         end
         if (wr_stat) begin
            en_q <= en_d;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h00000000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup && !mapped;
         if (setup && !pwrite) begin
            prdata_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         started_q <= 1'b0;
         link_q    <= 1'b0;
         speed_q   <= 1'b0;
         duplex_q  <= 1'b0;
         aneg_q    <= 1'b0;
         fc_over_q <= 1'b0;
         re_over_q <= 1'b0;
      end else begin
         started_q <= 1'b1;
         link_q    <= link_up;
         speed_q   <= speed_100;
         duplex_q  <= full_duplex;
         aneg_q    <= aneg_done;
         fc_over_q <= fc_over;
         re_over_q <= re_over;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_o_q  <= 1'b1;
         pin_oe_q <= 1'b0;
         pwdn_q   <= 1'b0;
         col_q    <= 1'b0;
      end else begin
         pin_o_q  <= pin_o_d;
         pin_oe_q <= pin_oe_d;
         pwdn_q   <= pwdn_d;
         col_q    <= col_d;
      end
   end

   assign prdata                  = prdata_q;
   assign pready                  = pready_q;
   assign pslverr                 = pslverr_q;
   assign irq_or_powerdown_pin_o  = pin_o_q;
   assign irq_or_powerdown_pin_oe = pin_oe_q;
   assign powerdown_req           = pwdn_q;
   assign collision_out           = col_q;

endmodule : pevic_top

// ===== testbench/pevic_top_asserts.sv
`timescale 1ns/10ps
module pevic_top_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        full_duplex,
   input wire logic        collision_raw,
   input wire logic        collision_out,
   input wire logic        irq_or_powerdown_pin_i,
   input wire logic        irq_or_powerdown_pin_o,
   input wire logic        irq_or_powerdown_pin_oe,
   input wire logic        powerdown_req
);
   // A shadow of the control bits lets the pin checks work from bus traffic alone.
   logic [4:0] ctrl_q;
   wire ctrl_wr = psel && penable && pready && pwrite && paddr == pevic_pkg::CTRL_ADDR && pstrb[0];
   wire rd_acc = pready && !pwrite;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) ctrl_q <= pevic_pkg::CTRL_RST;
      else if (ctrl_wr) ctrl_q <= pwdata[4:0];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy; psel && !penable |=> pready; endproperty
   property p_ctl; rd_acc && paddr == pevic_pkg::CTRL_ADDR |-> prdata == {27'h0, ctrl_q}; endproperty
   property p_sts; rd_acc && paddr == pevic_pkg::STAT_ADDR |-> (prdata & 32'hffffc0c0) == 32'h0; endproperty
   property p_tst; $past(ctrl_q[2]) |-> irq_or_powerdown_pin_o == !$past(ctrl_q[3]); endproperty
   property p_gen; $past(ctrl_q[2:1] == 2'h0) |-> irq_or_powerdown_pin_o == $past(ctrl_q[3]); endproperty
   property p_oe; $past(ctrl_q[0]) == ctrl_q[0] |-> irq_or_powerdown_pin_oe == ctrl_q[0]; endproperty
   property p_pd; $past(presetn) |-> powerdown_req == $past(!ctrl_q[0] && !irq_or_powerdown_pin_i); endproperty
   property p_col;
      $past(presetn) |-> collision_out == $past(collision_raw && (!full_duplex || ctrl_q[4]));
   endproperty
   a_rdy: assert property (p_rdy) else $error("pready missing after setup");
   a_ctl: assert property (p_ctl) else $error("control readback wrong");
   a_sts: assert property (p_sts) else $error("status reserved bits set");
   a_tst: assert property (p_tst) else $error("test interrupt not on pin");
   a_gen: assert property (p_gen) else $error("pin active without enable");
   a_oe: assert property (p_oe) else $error("pin enable wrong");
   a_pd: assert property (p_pd) else $error("power-down request wrong");
   a_col: assert property (p_col) else $error("collision output wrong");
   c_err: cover property (pslverr);
   c_irq: cover property (irq_or_powerdown_pin_oe && !irq_or_powerdown_pin_o);
   c_col: cover property (collision_out);
endmodule : pevic_top_asserts
bind pevic_top pevic_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .prdata, .pready, .pslverr, .full_duplex, .collision_raw, .collision_out, .irq_or_powerdown_pin_i,
   .irq_or_powerdown_pin_o, .irq_or_powerdown_pin_oe, .powerdown_req);

// ===== testbench/pevic_host_model.sv
`timescale 1ns/10ps
// While the pin is an input the host drives the power-down level, so the wire never floats.
module pevic_host_model (
   output wire logic pin,
   input  wire logic pin_o,
   input  wire logic pin_oe,
   input  wire logic pd_n
);
   assign pin = pin_oe ? pin_o : pd_n;
endmodule : pevic_host_model

// ===== testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} pevic_row_t;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pd_n = 1, col = 0;
   logic lk = 0, sp = 0, fd = 0, an = 0, pready, pslverr, col_o, pin_o, pin_oe, pdr;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic [7:0] fc = 0;
   logic [15:0] re = 0;
   logic e;
   wire pin;
   int errors = 0, total_checks = 0;
   pevic_row_t rows[7] = '{'{0, 12'h044, 0, 32'h08, 0}, '{0, 12'h048, 0, 0, 0}, '{1, 12'h044, 32'hff, 0, 0},
      '{0, 12'h044, 0, 32'h1f, 0}, '{1, 12'h048, 32'hffff, 0, 0}, '{0, 12'h048, 0, 32'h3f, 0},
      '{0, 12'h080, 0, 0, 1}};
   always #2.5 pclk = ~pclk;
   pevic_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_up(lk),
      .speed_100(sp), .full_duplex(fd), .aneg_done(an), .false_carrier_counter(fc), .receive_error_counter(re),
      .collision_raw(col), .collision_out(col_o), .irq_or_powerdown_pin_i(pin), .irq_or_powerdown_pin_o(pin_o),
      .irq_or_powerdown_pin_oe(pin_oe), .powerdown_req(pdr));
   pevic_host_model u_host (.pin(pin), .pin_o(pin_o), .pin_oe(pin_oe), .pd_n(pd_n));
   ////////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(string n, logic [31:0] x, logic [31:0] g);
      total_checks++;
      if (g !== x) begin
         $display("[FAIL] %s expected %h seen %h", n, x, g);
         errors++;
      end
   endtask : chk
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk iff pready === 1'b1);
      r = prdata; e = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   task automatic rd(logic [11:0] a, logic [31:0] x);
      apb(0, a, 0);
      chk("prdata", x, r);
   endtask : rd
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      #50000;
      errors++;
      finish_test;
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk("pslverr", rows[i].e, e);
         if (!rows[i].w) chk("row", rows[i].r, r);
      end
      apb(1, 12'h048, 0);
      $display("register rows done");
      // Counters sit exactly at half-full: that alone must not fire.
      lk <= 1; sp <= 1; fd <= 1; an <= 1; fc <= 8'h7f; re <= 16'h7fff;
      repeat (3) @(posedge pclk);
      rd(12'h048, 32'h3c00);
      fc <= 8'h80; re <= 16'h8000;
      rd(12'h048, 32'h0300);
      rd(12'h048, 0);
      $display("event flags done");
      apb(1, 12'h048, 32'h20);
      apb(1, 12'h044, 32'h0b);
      sp <= 0;
      repeat (4) @(posedge pclk);
      chk("pin", 1, pin);
      lk <= 0;
      repeat (4) @(posedge pclk);
      chk("pin", 0, pin);
      rd(12'h048, 32'h3020);
      repeat (3) @(posedge pclk);
      chk("pin", 1, pin);
      apb(1, 12'h044, 32'h03);
      repeat (3) @(posedge pclk);
      chk("pin", 0, pin);
      apb(1, 12'h044, 32'h05);
      repeat (3) @(posedge pclk);
      chk("pin", 1, pin);
      $display("pin tests done");
      apb(1, 12'h044, 0);
      pd_n <= 0; col <= 1;
      repeat (3) @(posedge pclk);
      chk("powerdown_req", 1, pdr);
      chk("collision_out", 0, col_o);
      apb(1, 12'h044, 32'h10);
      repeat (3) @(posedge pclk);
      chk("collision_out", 1, col_o);
      // Half duplex shows collision even with the full duplex enable clear.
      apb(1, 12'h044, 0);
      fd <= 0;
      repeat (3) @(posedge pclk);
      chk("collision_out", 1, col_o);
      $display("power-down and collision done");
      // Reset in mid-run: counters drop below half-full first so no crossing is pending.
      fc <= 8'h00; re <= 16'h0000; pd_n <= 1; fd <= 1;
      repeat (2) @(posedge pclk);
      presetn <= 0;
      repeat (2) @(posedge pclk);
      chk("pin_oe", 0, pin_oe);
      chk("pin_o", 1, pin_o);
      chk("powerdown_req", 0, pdr);
      chk("collision_out", 0, col_o);
      presetn <= 1;
      rd(12'h044, 32'h08);
      rd(12'h048, 0);
      chk("collision_out", 0, col_o);
      $display("mid-run reset done");
      finish_test;
   end
endmodule : tb_top
